// ### lpx_regs.svh
// constants of the led port expander serial interface
//
// Function
// - each rising serial clock shifts the data input into a 16-bit register
// - serial output updates on each falling serial clock with bit leaving
// - serial clock edges ignored while chip select is high
// - chip select rising latches the last sixteen bits shifted in
// - each input bit appears on serial output 15.5 clocks later
// - shared pin as clock input drives pwm; host keeps it at most 100kHz
// - shared pin defaults per variant and can be reconfigured either way
// - after power-up ports stay high impedance and device is in shutdown
// - each port selects static/pwm sink, open-drain output or logic input
// - each constant-current output has its own 8-bit pwm duty
// - each constant-current output has a 1-bit half/full current select
// - one 3-bit global setting scales all constant-current outputs
// - codes 0x03 to 0xFE run pwm; 0x00, 0x01, 0xFF leave it idle
// - run bit D0 of configuration clear gives shutdown, set resumes
`ifndef LPX_REGS_SVH
`define LPX_REGS_SVH
`define LPX_SHIFT_W 16
`define LPX_NPORTS 10
`define LPX_ADDR_MSB 14
`define LPX_ADDR_LSB 8
`define LPX_DATA_MSB 7
`define LPX_ADDR_PORT_LAST 7'h09
`define LPX_ADDR_CONFIG 7'h10
`define LPX_ADDR_FULL_LO 7'h13
`define LPX_ADDR_FULL_HI 7'h14
`define LPX_ADDR_GLOBAL 7'h15
`define LPX_CFG_RUN_BIT 0
`define LPX_CFG_CLKIN_BIT 1
`define LPX_CODE_LOW 8'h00
`define LPX_CODE_HIGH 8'h01
`define LPX_CODE_STATIC 8'h02
`define LPX_CODE_PWM_MIN 8'h03
`define LPX_CODE_PWM_MAX 8'hFE
`define LPX_CODE_OFF 8'hFF
`define LPX_GLOBAL_RESET 3'h7
`define LPX_GLOBAL_MSB 2
`define LPX_SYNC_IDLE 4'h3
`define LPX_FULL_LO_PORTS 8
`define LPX_CLK_HZ 100000000
`define LPX_INT_PWM_HZ 32000
`define LPX_PWM_DIV ((`LPX_CLK_HZ + `LPX_INT_PWM_HZ - 1) / `LPX_INT_PWM_HZ)
`define LPX_FIFO_DEPTH 8
`endif

// ### lpx_pkg.sv
// types of the led port expander serial interface
package lpx_pkg;
   typedef enum logic {LPX_PIN_SERIAL_OUT, LPX_PIN_CLOCK_IN} lpx_pin_mode_e;
   typedef logic [7:0] lpx_code_t;
endpackage

// ### lpx_word_if.sv
// word stream carrier between the serial front end and the register writer
`timescale 1ns/10ps
interface lpx_word_if #(
   parameter int WIDTH = 16
) ();
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ### lpx_fifo.sv
// word fifo with valid and ready on both sides
`timescale 1ns/10ps
module lpx_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   lpx_word_if.snk wr,
   lpx_word_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   wire empty = (wptr == rptr);
   wire push = wr.valid && !full;
   wire pop = rd.ready && !empty;

   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem[rptr[AW-1:0]];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (pop) begin
            rptr <= rptr + 1'b1;
         end
      end
   end
endmodule // lpx_fifo

// ### lpx_pwm.sv
// pwm phase counter on internal divider or external clock
`timescale 1ns/10ps
module lpx_pwm #(
   parameter int DIV = 3125
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic use_ext_i,
   input wire logic ext_rise_i,
   output logic [7:0] phase_o
);
   logic [$clog2(DIV)-1:0] div;
   wire int_tick = (div == '0);
   wire tick = use_ext_i ? ext_rise_i : int_tick;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div <= '0;
         phase_o <= 8'h00;
      end else if (!enable_i) begin
         div <= '0;
         phase_o <= 8'h00;
      end else begin
         div <= int_tick ? $bits(div)'(DIV - 1) : div - 1'b1;
         if (tick) begin
            phase_o <= phase_o + 8'h01;
         end
      end
   end
endmodule // lpx_pwm

// ### lpx_top.sv
// serial slave, port control and pwm of the led port expander
`timescale 1ns/10ps
`include "lpx_regs.svh"
module lpx_top
   import lpx_pkg::*;
#(
   parameter int NPORTS = `LPX_NPORTS,
   parameter int PWM_DIV = `LPX_PWM_DIV,
   parameter int FIFO_DEPTH = `LPX_FIFO_DEPTH,
   parameter bit CLKIN_DEFAULT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic din_i,
   input wire logic serial_out_or_pwm_clock_in_i,
   output logic serial_out_or_pwm_clock_in_o,
   output logic serial_out_or_pwm_clock_in_oe_o,
   input wire logic [NPORTS-1:0] io_port_pins_i,
   output logic [NPORTS-1:0] io_port_pins_o,
   output logic [NPORTS-1:0] io_port_pins_oe_o,
   output logic [NPORTS-1:0] port_in_o,
   output logic [NPORTS-1:0] mirror_on_o,
   output logic [NPORTS-1:0] full_current_o,
   output logic [2:0] global_current_o,
   output logic run_o,
   output logic pwm_running_o,
   output logic write_hold_i_ack_o,
   input wire logic write_hold_i,
   output logic word_dropped_o
);
   ////////////////////////////////////////////////////////////////////////
   // code decoding
   function automatic logic is_pwm(input lpx_code_t c);
      return (c >= `LPX_CODE_PWM_MIN) && (c <= `LPX_CODE_PWM_MAX);
   endfunction

   function automatic logic is_cc(input lpx_code_t c);
      return (c >= `LPX_CODE_STATIC) && (c <= `LPX_CODE_PWM_MAX);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   localparam int NSYNC = 4 + NPORTS;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [3:0] prev;
   wire [NSYNC-1:0] raw_in = {io_port_pins_i, serial_out_or_pwm_clock_in_i,
                              din_i, sclk_i, cs_n_i};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1 <= {{NPORTS{1'b0}}, `LPX_SYNC_IDLE};
         sync2 <= {{NPORTS{1'b0}}, `LPX_SYNC_IDLE};
         prev <= `LPX_SYNC_IDLE;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         prev <= sync2[3:0];
      end
   end

   wire cs_n_s = sync2[0];
   wire sclk_s = sync2[1];
   wire din_s = sync2[2];
   wire osc_s = sync2[3];
   wire sclk_rise = sclk_s && !prev[1];
   wire sclk_fall = !sclk_s && prev[1];
   wire cs_rise = cs_n_s && !prev[0];
   wire osc_rise = osc_s && !prev[3];
   wire selected = !cs_n_s;

   ////////////////////////////////////////////////////////////////////////
   // serial shift register and output
   logic [`LPX_SHIFT_W-1:0] shreg;
   logic sdo;
   lpx_pin_mode_e pin_mode;
   wire [`LPX_SHIFT_W-1:0] next_shreg = {shreg[`LPX_SHIFT_W-2:0], din_s};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shreg <= '0;
      end else if (selected && sclk_rise) begin
         shreg <= next_shreg;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sdo <= 1'b0;
      end else if (selected && sclk_fall) begin
         sdo <= shreg[`LPX_SHIFT_W-1];
      end
   end

   assign serial_out_or_pwm_clock_in_o = sdo;
   // push-pull drive only in serial output mode
   assign serial_out_or_pwm_clock_in_oe_o =
      (pin_mode == LPX_PIN_SERIAL_OUT);

   ////////////////////////////////////////////////////////////////////////
   // latched words through the fifo
   lpx_word_if #(.WIDTH(`LPX_SHIFT_W)) in_w ();
   lpx_word_if #(.WIDTH(`LPX_SHIFT_W)) out_w ();

   assign in_w.data = shreg;
   assign in_w.valid = cs_rise;

   lpx_fifo #(
      .WIDTH(`LPX_SHIFT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr(in_w.snk),
      .rd(out_w.src)
   );

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         word_dropped_o <= 1'b0;
      end else begin
         word_dropped_o <= cs_rise && !in_w.ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writer
   lpx_code_t out_code [NPORTS];
   logic [NPORTS-1:0] full_sel;
   logic [2:0] global_cur;
   logic run;

   assign out_w.ready = !write_hold_i;
   assign write_hold_i_ack_o = write_hold_i && out_w.valid;
   wire wr_en = out_w.valid && out_w.ready;
   wire [6:0] wr_addr = out_w.data[`LPX_ADDR_MSB:`LPX_ADDR_LSB];
   wire [7:0] wr_data = out_w.data[`LPX_DATA_MSB:0];
   wire wr_cfg = wr_en && (wr_addr == `LPX_ADDR_CONFIG);
   wire wr_full_lo = wr_en && (wr_addr == `LPX_ADDR_FULL_LO);
   wire wr_full_hi = wr_en && (wr_addr == `LPX_ADDR_FULL_HI);
   wire wr_global = wr_en && (wr_addr == `LPX_ADDR_GLOBAL);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         run <= 1'b0;
         pin_mode <= lpx_pin_mode_e'(CLKIN_DEFAULT);
      end else if (wr_cfg) begin
         run <= wr_data[`LPX_CFG_RUN_BIT];
         pin_mode <= lpx_pin_mode_e'(wr_data[`LPX_CFG_CLKIN_BIT]);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         global_cur <= `LPX_GLOBAL_RESET;
      end else if (wr_global) begin
         global_cur <= wr_data[`LPX_GLOBAL_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pwm phase
   logic [7:0] phase;
   logic [NPORTS-1:0] pwm_req;
   wire pwm_enable = run && (|pwm_req);

   lpx_pwm #(
      .DIV(PWM_DIV)
   ) u_pwm (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(pwm_enable),
      .use_ext_i(pin_mode == LPX_PIN_CLOCK_IN),
      .ext_rise_i(osc_rise),
      .phase_o(phase)
   );

   ////////////////////////////////////////////////////////////////////////
   // per-port configuration and drive
   genvar i;
   generate
      for (i = 0; i < NPORTS; i++) begin : g_port
         localparam logic [6:0] PADDR = 7'(i);
         localparam int FBIT = i % `LPX_FULL_LO_PORTS;
         wire wr_code = wr_en && (wr_addr == PADDR);
         wire wr_full = (i < `LPX_FULL_LO_PORTS) ? wr_full_lo : wr_full_hi;
         wire cc = is_cc(out_code[i]);
         wire pwm = is_pwm(out_code[i]);
         wire on_time = !pwm || (phase < out_code[i]);
         wire sink_cc = cc && run && on_time;
         wire sink_low = (out_code[i] == `LPX_CODE_LOW);

         assign pwm_req[i] = pwm;

         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               out_code[i] <= `LPX_CODE_OFF;
               full_sel[i] <= 1'b0;
            end else begin
               if (wr_code) begin
                  out_code[i] <= wr_data;
               end
               if (wr_full) begin
                  full_sel[i] <= wr_data[FBIT];
               end
            end
         end

         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               io_port_pins_oe_o[i] <= 1'b0;
               mirror_on_o[i] <= 1'b0;
            end else begin
               io_port_pins_oe_o[i] <= sink_low || sink_cc;
               mirror_on_o[i] <= sink_cc;
            end
         end
      end
   endgenerate

   assign io_port_pins_o = '0;
   assign port_in_o = sync2[NSYNC-1:4];
   assign full_current_o = full_sel;
   assign global_current_o = global_cur;
   assign run_o = run;
   assign pwm_running_o = pwm_enable;
endmodule // lpx_top

// ### lpx_top_props.sv
// assertions on the expander top ports
`timescale 1ns/10ps
module lpx_top_props #(
   parameter int NPORTS = 10,
   parameter bit CLKIN_DEFAULT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic serial_out_or_pwm_clock_in_o,
   input wire logic serial_out_or_pwm_clock_in_oe_o,
   input wire logic [NPORTS-1:0] io_port_pins_o,
   input wire logic [NPORTS-1:0] io_port_pins_oe_o,
   input wire logic [NPORTS-1:0] mirror_on_o,
   input wire logic [NPORTS-1:0] full_current_o,
   input wire logic [2:0] global_current_o,
   input wire logic run_o,
   input wire logic pwm_running_o,
   input wire logic word_dropped_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rel; $fell(rst_i); endsequence
   sequence s_cs_idle; cs_n_i [*6]; endsequence
   property p_power_up;
      s_rel |-> io_port_pins_oe_o == '0 && mirror_on_o == '0 && !run_o;
   endproperty
   a_power_up: assert property (p_power_up)
      else $error("ports active after reset");
   property p_pin_mode;
      s_rel |-> serial_out_or_pwm_clock_in_oe_o == !CLKIN_DEFAULT;
   endproperty
   a_pin_mode: assert property (p_pin_mode)
      else $error("shared pin mode wrong after reset");
   property p_cur_reset;
      s_rel |-> global_current_o == 3'h7 && full_current_o == '0;
   endproperty
   a_cur_reset: assert property (p_cur_reset)
      else $error("current settings wrong after reset");
   property p_open_drain;
      io_port_pins_o == '0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("port driven high");
   property p_cs_ignore;
      s_cs_idle |=> $stable(serial_out_or_pwm_clock_in_o);
   endproperty
   a_cs_ignore: assert property (p_cs_ignore)
      else $error("serial out moved with select high");
   property p_out_fall;
      $changed(serial_out_or_pwm_clock_in_o) |-> !$past(sclk_i, 2);
   endproperty
   a_out_fall: assert property (p_out_fall)
      else $error("serial out moved without falling clock");
   property p_mirror_run;
      |mirror_on_o |-> run_o || $past(run_o) || $past(run_o, 2);
   endproperty
   a_mirror_run: assert property (p_mirror_run)
      else $error("sink on in shutdown");
   property p_mirror_oe;
      (mirror_on_o & ~io_port_pins_oe_o) == '0;
   endproperty
   a_mirror_oe: assert property (p_mirror_oe)
      else $error("mirror on without sink");
   property p_drop;
      word_dropped_o |=> !word_dropped_o ##0 cs_n_i;
   endproperty
   a_drop: assert property (p_drop)
      else $error("drop pulse too long");
   property p_pwm_run;
      pwm_running_o |-> run_o;
   endproperty
   a_pwm_run: assert property (p_pwm_run)
      else $error("pwm running in shutdown");
endmodule // lpx_top_props

// ### lpx_host.sv
// serial master model driving the expander link
`timescale 1ns/10ps
module lpx_host (
   input wire logic clk_i,
   input wire logic sdo_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic din_o,
   output logic osc_o
);
   logic [63:0] echo;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
      din_o = 1'b0;
      osc_o = 1'b0;
      echo = '0;
   end
   // n bits msb first, echo taken before each rising edge
   task automatic frame(input logic [63:0] w, input int n);
      @(negedge clk_i);
      #1 cs_n_o = 1'b0;
      #125;
      for (int i = n - 1; i >= 0; i--) begin
         sclk_o = 1'b0;
         din_o = w[i];
         #62.5 echo = {echo[62:0], sdo_i};
         sclk_o = 1'b1;
         #62.5;
      end
      cs_n_o = 1'b1;
      din_o = ~din_o;
      #250;
   endtask
   // clock toggles while select stays high
   task automatic idle(input int n);
      @(negedge clk_i);
      #1;
      repeat (n) begin
         sclk_o = 1'b0;
         din_o = ~din_o;
         #62.5 sclk_o = 1'b1;
         #62.5;
      end
   endtask
   task automatic ext(input int n);
      repeat (n) begin
         #5000 osc_o = 1'b1;
         #5000 osc_o = 1'b0;
      end
   endtask
endmodule // lpx_host

// ### testbench.sv
// self-checking bench of the expander top
`timescale 1ns/10ps
module testbench;
   import lpx_pkg::*;
   logic clk_i, rst_i, write_hold_i, cs_n, sclk, din, osc, sdo, soe, pin;
   logic run, pwm, ack, drop, rm, cm;
   logic [9:0] pins, pin_in, oe_p, mir, full, fm;
   logic [2:0] glob, gm;
   logic [7:0] code [10];
   logic [7:0] tbl [8] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'hff, 8'h03, 8'hfe,
      8'h02};
   logic hist [$];
   int err_count = 0, comparisons = 0, seed, drops = 0;
   assign pin = soe ? sdo : osc;
   localparam int DIV = 8;
   lpx_top #(.PWM_DIV(DIV)) u_lpx_top (.clk_i(clk_i), .rst_i(rst_i),
      .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
      .serial_out_or_pwm_clock_in_i(pin), .serial_out_or_pwm_clock_in_o(sdo),
      .serial_out_or_pwm_clock_in_oe_o(soe), .io_port_pins_i(pins),
      .io_port_pins_o(), .io_port_pins_oe_o(oe_p), .port_in_o(pin_in),
      .mirror_on_o(mir), .full_current_o(full), .global_current_o(glob),
      .run_o(run), .pwm_running_o(pwm), .write_hold_i_ack_o(ack),
      .write_hold_i(write_hold_i), .word_dropped_o(drop));
   lpx_host u_lpx_host (.clk_i(clk_i), .sdo_i(pin), .cs_n_o(cs_n),
      .sclk_o(sclk), .din_o(din), .osc_o(osc));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (drop === 1'b1) drops <= drops + 1;
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic ck(input logic c, input string m);
      comparisons++;
      if (c !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   function automatic void apply(input logic [15:0] w);
      if (w[14:8] <= 7'h09) code[w[14:8]] = w[7:0];
      else if (w[14:8] == 7'h10) {cm, rm} = w[1:0];
      else if (w[14:8] == 7'h13) fm[7:0] = w[7:0];
      else if (w[14:8] == 7'h14) fm[9:8] = w[1:0];
      else if (w[14:8] == 7'h15) gm = w[2:0];
   endfunction
   task automatic send(input logic [63:0] w, input int n);
      logic e;
      e = !cm;
      u_lpx_host.frame(w, n);
      for (int i = n - 1; i >= 0; i--) begin
         if (e && hist.size() >= 16)
            ck(u_lpx_host.echo[i] === hist[hist.size()-16], "echo");
         hist.push_back(w[i]);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      send(64'({1'b0, a, d}), 16);
      apply({1'b0, a, d});
   endtask
   task automatic chk;
      logic pw, c2;
      pw = 1'b0;
      ck(run === rm && glob === gm && full === fm, "regs");
      ck(soe === !cm, "pin mode");
      for (int p = 0; p < 10; p++) begin
         c2 = code[p] == 8'h02 && rm;
         pw |= code[p] inside {[8'h03:8'hfe]};
         if (!(code[p] inside {[8'h03:8'hfe]}))
            ck({oe_p[p], mir[p]} === {code[p] == 8'h00 || c2, c2}, "port");
      end
      ck(pwm === (rm && pw), "pwm");
   endtask
   // on-cycles of each pwm port over one full phase period
   task automatic duty;
      int on [10] = '{default: 0};
      repeat (256 * DIV) begin
         @(negedge clk_i);
         foreach (on[p]) on[p] += mir[p];
      end
      foreach (on[p])
         if (code[p] inside {[8'h03:8'hfe]})
            ck(on[p] == (rm ? code[p] * DIV : 0), "duty");
   endtask
   initial begin
      seed = 67265;
      rst_i = 1'b1;
      write_hold_i = 1'b0;
      pins = 10'h000;
      code = '{default: 8'hff};
      {cm, rm, fm, gm} = {2'b00, 10'h000, 3'h7};
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk();
      $display("test reset done");
      wr(7'h10, 8'h01);
      foreach (tbl[i]) wr(7'(i), tbl[i]);
      wr(7'h13, 8'($random(seed)));
      wr(7'h14, 8'($random(seed)));
      wr(7'h15, 8'($random(seed)));
      wr(7'h2a, 8'h55);
      chk();
      duty();
      $display("test codes done");
      send(64'({8'($random(seed)), 16'h0902}), 24);
      apply(16'h0902);
      wr(7'h10, 8'h00);
      chk();
      duty();
      u_lpx_host.idle(20);
      wr(7'h10, 8'h01);
      chk();
      $display("test shutdown done");
      @(posedge clk_i) write_hold_i <= 1'b1;
      for (int i = 0; i < 9; i++) send(64'({8'h15, 8'(i)}), 16);
      ck(drops == 1 && ack === 1'b1 && glob === gm, "hold");
      @(posedge clk_i) write_hold_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      gm = 3'h7;
      chk();
      $display("test fifo done");
      wr(7'h10, 8'h00);
      wr(7'h10, 8'h03);
      ck({mir[3], mir[5]} === {0 < tbl[3], 0 < tbl[5]}, "ext idle");
      u_lpx_host.ext(4);
      ck({mir[3], mir[5]} === {4 < tbl[3], 4 < tbl[5]}, "ext pwm");
      chk();
      wr(7'h10, 8'h01);
      chk();
      @(posedge clk_i) pins <= 10'($random(seed));
      repeat (4) @(posedge clk_i);
      ck(pin_in === pins, "port input");
      $display("test pins done");
      @(posedge clk_i) rst_i <= 1'b1;
      code = '{default: 8'hff};
      {cm, rm, fm, gm} = {2'b00, 10'h000, 3'h7};
      hist.delete();
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk();
      wr(7'h10, 8'h01);
      chk();
      $display("test second reset done");
      summarize();
   end
   initial begin
      #500000;
      err_count++;
      $display("[FAIL] %0t watchdog", $time);
      summarize();
   end
endmodule // testbench
bind lpx_top lpx_top_props #(.NPORTS(NPORTS), .CLKIN_DEFAULT(CLKIN_DEFAULT))
   u_lpx_top_props (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .sclk_i(sclk_i), .serial_out_or_pwm_clock_in_o(serial_out_or_pwm_clock_in_o),
   .serial_out_or_pwm_clock_in_oe_o(serial_out_or_pwm_clock_in_oe_o),
   .io_port_pins_o(io_port_pins_o), .io_port_pins_oe_o(io_port_pins_oe_o),
   .mirror_on_o(mirror_on_o), .full_current_o(full_current_o),
   .global_current_o(global_current_o), .run_o(run_o),
   .pwm_running_o(pwm_running_o), .word_dropped_o(word_dropped_o));
